// >>> iopbm_cond.sv
`timescale 1ns/1ps
`default_nettype none
`include "iopbm_regs.svh"
// condition evaluation of a transfer control instruction
module iopbm_cond
   import iopbm_pkg::*;
(
   // instruction word
   input wire logic [31:0] instr,
   // live state
   input wire logic alu_carry,
   input wire logic [2:0] latched_phase,
   input wire logic [7:0] first_received_byte,
   input wire logic initiator_mode,
   input wire logic attention_active,
   // result
   output logic taken
);
   // ----------------------------------------
   // compares
   // ----------------------------------------
   wire logic [7:0] dmask = instr[15:8];
   wire logic [7:0] dval = instr[7:0];
   // mask bit one ignores that bit
   wire logic data_true = ((first_received_byte ^ dval) & ~dmask) == 8'h00;
   // phase match or attention test
   wire logic phase_true = initiator_mode ?
      (latched_phase == instr[`IOPBM_PHASE_HI:`IOPBM_PHASE_LO]) : attention_active;
   wire logic use_d = instr[`IOPBM_DCMP_BIT];
   wire logic use_p = instr[`IOPBM_PCMP_BIT];
   wire logic sense = instr[`IOPBM_SENSE_BIT];
   // both enabled: all true or all false
   wire logic all_true = (!use_d || data_true) && (!use_p || phase_true);
   wire logic all_false = (!use_d || !data_true) && (!use_p || !phase_true);
   wire logic any_cmp = use_d || use_p;
   // carry test alone, sense selects polarity
   wire logic carry_hit = sense ? alu_carry : !alu_carry;
   wire logic cmp_hit = sense ? all_true : all_false;
   assign taken = instr[`IOPBM_CARRY_BIT] ? carry_hit : (any_cmp ? cmp_hit : 1'b1);
endmodule // iopbm_cond
`default_nettype wire

// >>> iopbm_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "iopbm_regs.svh"
module iopbm_core
   import iopbm_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // instruction fetch: pointer out, three words in with the acknowledge
   output logic fetch_req,
   output logic [31:0] fetch_addr,
   input wire logic fetch_ack,
   input wire logic [31:0] fetch_word0,
   input wire logic [31:0] fetch_word1,
   input wire logic [31:0] fetch_word2,
   // memory move burst port
   output logic move_req,
   output logic [31:0] move_src,
   output logic [31:0] move_dst,
   output logic move_src_io,
   output logic move_dst_io,
   input wire logic move_ack,
   // peripheral bus state (pins)
   input wire logic bus_request_line_n,
   input wire logic bus_attention_line_n,
   input wire logic [2:0] bus_phase_pins,
   input wire logic initiator_mode,
   // core state
   input wire logic alu_carry,
   input wire logic [7:0] first_received_byte,
   // host interrupt
   output logic irq_n
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [4:0] sync1; // first stage, read only by sync2
   logic [4:0] sync2; // second stage
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         sync1 <= 5'h1F;
         sync2 <= 5'h1F;
      end else begin
         sync1 <= {bus_request_line_n, bus_attention_line_n, bus_phase_pins};
         sync2 <= sync1;
      end
   end
   wire logic req_n_s = sync2[4];
   wire logic atn_active = !sync2[3];
   logic req_n_d; // previous request level
   logic [2:0] latched_phase; // phase lines caught on request
   logic phase_new; // unserviced phase request pending
   wire logic req_fall = req_n_d && !req_n_s;
   // ----------------------------------------
   // registers
   // ----------------------------------------
   iopbm_state_t state;
   logic [31:0] ip; // instruction pointer
   logic [31:0] operand_address_reg; // second instruction word
   logic [31:0] return_reg; // single return level
   logic [31:0] data_structure_base; // base register
   logic [2:0] interrupt_status_reg; // on-the-fly, illegal, halted
   logic [7:0] dma_mode_reg;
   logic [31:0] instr; // first word of the executing instruction
   logic [31:0] next_address_reg; // move destination
   logic [23:0] byte_count; // remaining move bytes
   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire logic [1:0] itype = instr[`IOPBM_TYPE_HI:`IOPBM_TYPE_LO];
   wire logic opcode_bit_two = instr[`IOPBM_OPC_HI];
   wire logic [2:0] opc = instr[`IOPBM_OPC_HI:`IOPBM_OPC_LO];
   wire logic is_xfer = itype == `IOPBM_TYPE_XFER;
   wire logic is_move = itype == `IOPBM_TYPE_MMOVE;
   // top bit set is reserved
   wire logic xfer_ill = is_xfer && opcode_bit_two;
   wire logic is_jump = opc == IOPBM_OP_JUMP;
   wire logic is_call = opc == IOPBM_OP_CALL;
   wire logic is_ret = opc == IOPBM_OP_RET;
   wire logic is_int = opc == IOPBM_OP_INT;
   // relative only for jump and call
   wire logic use_rel = instr[`IOPBM_REL_BIT] && (is_jump || is_call);
   // sign-extended offset added to next pointer
   wire logic [31:0] rel_target = ip + {{8{operand_address_reg[23]}}, operand_address_reg[23:0]};
   // compare deferred on wait bit
   wire logic need_wait = instr[`IOPBM_WAIT_BIT]
      && (instr[`IOPBM_DCMP_BIT] || instr[`IOPBM_PCMP_BIT]);
   wire logic cond_ready = !need_wait || phase_new;
   wire logic cond_taken;
   iopbm_cond u_cond (
      .instr(instr),
      .alu_carry(alu_carry),
      .latched_phase(latched_phase),
      .first_received_byte(first_received_byte),
      .initiator_mode(initiator_mode),
      .attention_active(atn_active),
      .taken(cond_taken)
   );
   // move checks
   wire logic move_misalign = operand_address_reg[1:0] != next_address_reg[1:0];
   wire logic move_resv = instr[`IOPBM_MMRES_HI:`IOPBM_MMRES_LO] != 4'h0;
   wire logic move_ill = is_move && (move_misalign || move_resv);
   wire logic ill = xfer_ill || move_ill || (!is_xfer && !is_move);
   wire logic int_fire = state == IOPBM_ST_EXEC && is_xfer && !xfer_ill && is_int
      && cond_ready && cond_taken;
   wire logic ip_write = reg_wr && reg_addr == `IOPBM_OFS_IP;
   wire logic [23:0] chunk = byte_count < `IOPBM_BURST ? byte_count : `IOPBM_BURST;
   // ----------------------------------------
   // request latch
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         req_n_d <= 1'b1;
         latched_phase <= 3'h0;
         phase_new <= 1'b0;
      end else begin
         req_n_d <= req_n_s;
         if (req_fall) begin
            latched_phase <= sync2[2:0];
            phase_new <= 1'b1; // a new request wins over consumption
         end else if (state == IOPBM_ST_EXEC && is_xfer && need_wait && phase_new) begin
            phase_new <= 1'b0;
         end
      end
   end
   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state <= IOPBM_ST_IDLE;
         ip <= 32'h00000000;
         operand_address_reg <= 32'h00000000;
         return_reg <= 32'h00000000;
         instr <= 32'h00000000;
         next_address_reg <= 32'h00000000;
         byte_count <= 24'h000000;
         irq_n <= 1'b1;
      end else begin
         case (state)
            IOPBM_ST_IDLE, IOPBM_ST_HALT: begin
               // pointer write resumes
               if (ip_write) begin
                  ip <= reg_wdata;
                  irq_n <= 1'b1;
                  state <= IOPBM_ST_FETCH;
               end
            end
            IOPBM_ST_FETCH: begin
               if (fetch_ack) begin
                  instr <= fetch_word0;
                  // vector kept readable
                  operand_address_reg <= fetch_word1;
                  next_address_reg <= fetch_word2;
                  byte_count <= fetch_word0[23:0];
                  ip <= ip + (fetch_word0[31:30] == `IOPBM_TYPE_MMOVE ?
                     `IOPBM_IP_STEP + `IOPBM_ABS_STEP : `IOPBM_IP_STEP);
                  state <= IOPBM_ST_EXEC;
               end
            end
            IOPBM_ST_EXEC: begin
               if (ill) begin
                  state <= IOPBM_ST_HALT;
               end else if (is_move) begin
                  // bursts until count is zero
                  state <= byte_count == 24'h000000 ? IOPBM_ST_FETCH : IOPBM_ST_MOVE;
               end else if (cond_ready) begin
                  if (!cond_taken) begin
                     state <= IOPBM_ST_FETCH; // pointer untouched
                  end else if (is_ret) begin
                     ip <= return_reg; // no call check
                     state <= IOPBM_ST_FETCH;
                  end else if (is_int) begin
                     if (instr[`IOPBM_IOTF_BIT]) begin
                        state <= IOPBM_ST_FETCH; // on the fly
                     end else begin
                        irq_n <= 1'b0;
                        state <= IOPBM_ST_HALT;
                     end
                  end else begin
                     if (is_call) begin
                        return_reg <= ip;
                     end
                     if (use_rel) begin
                        ip <= rel_target;
                        state <= IOPBM_ST_FETCH;
                     end else begin
                        ip <= operand_address_reg;
                        state <= IOPBM_ST_ABSF;
                     end
                  end
               end
            end
            IOPBM_ST_ABSF: begin
               // fetch at target, then pointer = target + 4
               if (fetch_ack) begin
                  instr <= fetch_word0;
                  operand_address_reg <= fetch_word1;
                  next_address_reg <= fetch_word2;
                  byte_count <= fetch_word0[23:0];
                  ip <= ip + `IOPBM_ABS_STEP;
                  state <= IOPBM_ST_EXEC;
               end
            end
            IOPBM_ST_MOVE: begin
               if (move_ack) begin
                  // staged burst done
                  operand_address_reg <= operand_address_reg + {8'h00, chunk};
                  next_address_reg <= next_address_reg + {8'h00, chunk};
                  byte_count <= byte_count - chunk;
                  if (byte_count == chunk) begin
                     state <= IOPBM_ST_FETCH;
                  end
               end
            end
            default: begin
               state <= IOPBM_ST_IDLE;
            end
         endcase
      end
   end
   // ----------------------------------------
   // software registers
   // ----------------------------------------
   wire logic ill_event = state == IOPBM_ST_EXEC && ill;
   wire logic iotf_event = state == IOPBM_ST_EXEC && is_xfer && !xfer_ill && is_int
      && cond_ready && cond_taken && instr[`IOPBM_IOTF_BIT];
   wire logic interrupt_status_reg_wr = reg_wr && reg_addr == `IOPBM_OFS_INTERRUPT_STATUS_REG;
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         interrupt_status_reg <= 3'h0;
         dma_mode_reg <= 8'h00;
         data_structure_base <= 32'h00000000;
      end else begin
         // write one clears; hardware set wins
         interrupt_status_reg <= (interrupt_status_reg & ~(interrupt_status_reg_wr ? reg_wdata[2:0] : 3'h0))
            | {iotf_event, ill_event, int_fire && !instr[`IOPBM_IOTF_BIT]};
         if (reg_wr && reg_addr == `IOPBM_OFS_DMA_MODE_REG) begin
            dma_mode_reg <= reg_wdata[7:0];
         end
         // only software writes it; moves leave it alone
         if (reg_wr && reg_addr == `IOPBM_OFS_DSB) begin
            data_structure_base <= reg_wdata;
         end
      end
   end
   // ----------------------------------------
   // read port
   // ----------------------------------------
   logic [31:0] next_rdata;
   always_comb begin
      case (reg_addr)
         `IOPBM_OFS_IP: next_rdata = ip;
         `IOPBM_OFS_OPERAND: next_rdata = operand_address_reg;
         `IOPBM_OFS_RETURN: next_rdata = return_reg;
         `IOPBM_OFS_DSB: next_rdata = data_structure_base;
         `IOPBM_OFS_INTERRUPT_STATUS_REG: next_rdata = {29'h0, interrupt_status_reg};
         `IOPBM_OFS_DMA_MODE_REG: next_rdata = {24'h0, dma_mode_reg};
         `IOPBM_OFS_CTRL: next_rdata = {26'h0, state};
         `IOPBM_OFS_MOVE: next_rdata = {8'h00, byte_count};
         default: next_rdata = 32'h00000000;
      endcase
   end
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         reg_rdata <= 32'h00000000;
      end else begin
         reg_rdata <= reg_rd ? next_rdata : 32'h00000000;
      end
   end
   // ----------------------------------------
   // outputs
   // ----------------------------------------
   wire logic source_in_io_space = dma_mode_reg[`IOPBM_SOURCE_IN_IO_SPACE_BIT];
   wire logic dest_in_io_space = dma_mode_reg[`IOPBM_DEST_IN_IO_SPACE_BIT];
   assign fetch_req = state == IOPBM_ST_FETCH || state == IOPBM_ST_ABSF;
   assign fetch_addr = ip;
   assign move_req = state == IOPBM_ST_MOVE;
   assign move_src = operand_address_reg;
   assign move_dst = next_address_reg;
   assign move_src_io = source_in_io_space;
   assign move_dst_io = dest_in_io_space;
   // ----------------------------------------
   // checks
   // ----------------------------------------
   chk_call_saves: assert property (@(posedge sys_clk) disable iff (!reset_n)
      state == IOPBM_ST_EXEC && is_xfer && !xfer_ill && is_call && cond_ready && cond_taken
      |=> return_reg == $past(ip)) else $error("call did not save pointer");
   chk_ret_loads: assert property (@(posedge sys_clk) disable iff (!reset_n)
      state == IOPBM_ST_EXEC && is_xfer && !xfer_ill && is_ret && cond_ready && cond_taken
      |=> ip == $past(return_reg)) else $error("return did not reload pointer");
   chk_int_irq: assert property (@(posedge sys_clk) disable iff (!reset_n)
      int_fire && !instr[`IOPBM_IOTF_BIT] |=> !irq_n && state == IOPBM_ST_HALT)
      else $error("interrupt not raised");
   chk_halt_stays: assert property (@(posedge sys_clk) disable iff (!reset_n)
      state == IOPBM_ST_HALT && !ip_write |=> state == IOPBM_ST_HALT)
      else $error("left halt without pointer write");
   chk_iotf_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
      iotf_event |=> interrupt_status_reg[2] && irq_n && state == IOPBM_ST_FETCH)
      else $error("on-the-fly wrong");
   chk_rel_target: assert property (@(posedge sys_clk) disable iff (!reset_n)
      state == IOPBM_ST_EXEC && is_xfer && !xfer_ill && use_rel && cond_ready && cond_taken
      && (is_jump || is_call) |=> ip == $past(rel_target)) else $error("relative target wrong");
   chk_not_taken: assert property (@(posedge sys_clk) disable iff (!reset_n)
      state == IOPBM_ST_EXEC && is_xfer && !ill && cond_ready && !cond_taken
      |=> $stable(ip) && state == IOPBM_ST_FETCH) else $error("not taken changed pointer");
   chk_wait_stall: assert property (@(posedge sys_clk) disable iff (!reset_n)
      state == IOPBM_ST_EXEC && is_xfer && !ill && need_wait && !phase_new
      |=> state == IOPBM_ST_EXEC) else $error("compare did not wait for request");
   chk_abs_step: assert property (@(posedge sys_clk) disable iff (!reset_n)
      state == IOPBM_ST_ABSF && fetch_ack |=> ip == $past(ip) + 32'h00000004)
      else $error("absolute pointer step wrong");
   chk_move_ill: assert property (@(posedge sys_clk) disable iff (!reset_n)
      state == IOPBM_ST_EXEC && is_move && move_misalign |=> interrupt_status_reg[1])
      else $error("misaligned move not flagged");
   chk_dsb_kept: assert property (@(posedge sys_clk) disable iff (!reset_n)
      state == IOPBM_ST_MOVE && !reg_wr |=> $stable(data_structure_base))
      else $error("base changed by move");
   cov_call: cover property (@(posedge sys_clk) state == IOPBM_ST_EXEC && is_call && cond_taken);
   cov_halt: cover property (@(posedge sys_clk) !irq_n);
   cov_move: cover property (@(posedge sys_clk) move_req && move_ack);
endmodule // iopbm_core
`default_nettype wire

// >>> iopbm_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// host memory model: instruction fetch and move bursts
// ----------------------------------------
module iopbm_mem_model (
   // clock
   input wire logic sys_clk,
   // instruction fetch
   input wire logic fetch_req,
   input wire logic [31:0] fetch_addr,
   output logic fetch_ack,
   output logic [31:0] fetch_word0,
   output logic [31:0] fetch_word1,
   output logic [31:0] fetch_word2,
   // move bursts
   input wire logic move_req,
   input wire logic [31:0] move_src,
   input wire logic [31:0] move_dst,
   input wire logic move_src_io,
   input wire logic move_dst_io,
   output logic move_ack
);
   logic [31:0] mem [logic [31:0]]; // program image, loaded by the bench
   logic slow; // three wait cycles before each answer when set
   int wt; // wait cycles spent on the pending request
   int n_bursts; // bursts answered since the bench last cleared it
   logic [65:0] first_burst; // {src_io, dst_io, src, dst} of the first burst
   // unknown addresses read as zero
   function automatic logic [31:0] word_at(input logic [31:0] a);
      return mem.exists(a) ? mem[a] : 32'h00000000;
   endfunction
   initial begin
      {fetch_ack, move_ack, slow} = 3'h0;
      {fetch_word0, fetch_word1, fetch_word2} = 96'h0;
      {wt, n_bursts} = 0;
   end
   // one-cycle acknowledge; words toggle outside the ack cycle so stale data never looks valid
   always @(posedge sys_clk) begin
      fetch_ack <= 1'b0;
      move_ack <= 1'b0;
      fetch_word0 <= ~fetch_word0;
      fetch_word1 <= ~fetch_word1;
      fetch_word2 <= ~fetch_word2;
      if ((fetch_req || move_req) && !fetch_ack && !move_ack) begin
         if (wt < (slow ? 3 : 0)) begin
            wt <= wt + 1;
         end else if (fetch_req) begin
            wt <= 0;
            fetch_ack <= 1'b1;
            fetch_word0 <= word_at(fetch_addr);
            fetch_word1 <= word_at(fetch_addr + 32'h00000004);
            fetch_word2 <= word_at(fetch_addr + 32'h00000008);
         end else begin
            wt <= 0;
            move_ack <= 1'b1;
            if (n_bursts == 0) first_burst <= {move_src_io, move_dst_io, move_src, move_dst};
            n_bursts <= n_bursts + 1;
         end
      end
   end
endmodule // iopbm_mem_model
`default_nettype wire

// >>> iopbm_pkg.sv
`default_nettype none
package iopbm_pkg;
   // transfer control opcodes
   typedef enum logic [2:0] {
      IOPBM_OP_JUMP = 3'h0,
      IOPBM_OP_CALL = 3'h1,
      IOPBM_OP_RET = 3'h2,
      IOPBM_OP_INT = 3'h3
   } iopbm_op_t;
   // sequencer states, one-hot
   typedef enum logic [5:0] {
      IOPBM_ST_IDLE = 6'h01,
      IOPBM_ST_FETCH = 6'h02,
      IOPBM_ST_EXEC = 6'h04,
      IOPBM_ST_ABSF = 6'h08,
      IOPBM_ST_MOVE = 6'h10,
      IOPBM_ST_HALT = 6'h20
   } iopbm_state_t;
endpackage
`default_nettype wire

// >>> iopbm_regs.svh
`ifndef IOPBM_REGS_SVH
`define IOPBM_REGS_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define IOPBM_OFS_IP 8'h00
`define IOPBM_OFS_OPERAND 8'h04
`define IOPBM_OFS_RETURN 8'h08
`define IOPBM_OFS_DSB 8'h0C
`define IOPBM_OFS_INTERRUPT_STATUS_REG 8'h10
`define IOPBM_OFS_DMA_MODE_REG 8'h14
`define IOPBM_OFS_CTRL 8'h18
`define IOPBM_OFS_MOVE 8'h1C
// ----------------------------------------
// instruction fields
// ----------------------------------------
`define IOPBM_TYPE_HI 31
`define IOPBM_TYPE_LO 30
`define IOPBM_OPC_HI 29
`define IOPBM_OPC_LO 27
`define IOPBM_PHASE_HI 26
`define IOPBM_PHASE_LO 24
`define IOPBM_REL_BIT 23
`define IOPBM_CARRY_BIT 21
`define IOPBM_IOTF_BIT 20
`define IOPBM_SENSE_BIT 19
`define IOPBM_DCMP_BIT 18
`define IOPBM_PCMP_BIT 17
`define IOPBM_WAIT_BIT 16
`define IOPBM_MMRES_HI 28
`define IOPBM_MMRES_LO 25
`define IOPBM_TYPE_XFER 2'h2
`define IOPBM_TYPE_MMOVE 2'h3
`define IOPBM_SOURCE_IN_IO_SPACE_BIT 5
`define IOPBM_DEST_IN_IO_SPACE_BIT 4
`define IOPBM_INTERRUPT_STATUS_REG_IOTF_BIT 2
`define IOPBM_INTERRUPT_STATUS_REG_ILL_BIT 1
`define IOPBM_INTERRUPT_STATUS_REG_HALT_BIT 0
`define IOPBM_IP_STEP 32'h00000008
`define IOPBM_ABS_STEP 32'h00000004
`define IOPBM_BURST 24'h000004
`endif

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import iopbm_pkg::*;
   logic sys_clk, reset_n, reg_wr, reg_rd, fetch_req, fetch_ack, move_req, move_ack;
   logic move_src_io, move_dst_io, irq_n, bus_request_line_n, bus_attention_line_n;
   logic initiator_mode, alu_carry;
   logic [7:0] reg_addr, first_received_byte;
   logic [2:0] bus_phase_pins;
   logic [31:0] reg_wdata, reg_rdata, fetch_addr, fetch_word0, fetch_word1, fetch_word2;
   logic [31:0] move_src, move_dst, v;
   logic [31:0] bad_at [3] = '{32'h00000600, 32'h00000700, 32'h00000800};
   int err_total = 0;
   int n_compared = 0;
   int cyc = 0;
   iopbm_core dut (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .fetch_req, .fetch_addr, .fetch_ack, .fetch_word0, .fetch_word1, .fetch_word2,
      .move_req, .move_src, .move_dst, .move_src_io, .move_dst_io, .move_ack,
      .bus_request_line_n, .bus_attention_line_n, .bus_phase_pins, .initiator_mode,
      .alu_carry, .first_received_byte, .irq_n);
   iopbm_mem_model mem_model (.sys_clk, .fetch_req, .fetch_addr, .fetch_ack, .fetch_word0,
      .fetch_word1, .fetch_word2, .move_req, .move_src, .move_dst, .move_src_io,
      .move_dst_io, .move_ack);
   // ----------------------------------------
   // clock and hang guard
   // ----------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         complete_run();
      end
   end
   // ----------------------------------------
   // access tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge sys_clk) reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge sys_clk) reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // poll the status register until a masked bit shows, bounded
   task automatic wstat(input logic [31:0] m);
      v = 32'h0;
      for (int i = 0; i < 300 && (v & m) == 32'h0; i++) rd(8'h10, v);
   endtask
   // load one two-word instruction into the program image
   task automatic ld(input logic [31:0] a, input logic [31:0] w0, input logic [31:0] w1);
      mem_model.mem[a] = w0;
      mem_model.mem[a + 32'h00000004] = w1;
   endtask
   task automatic complete_run();
      if (err_total == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {bus_request_line_n, bus_attention_line_n, initiator_mode} = 3'h7;
      {bus_phase_pins, alu_carry, first_received_byte} = '0;
      // phase field left clear where unused; no carry mixed with compares
      ld(32'h00000100, 32'h88080000, 32'h00000200); // call, unconditional
      ld(32'h00000200, 32'h90080000, 32'h00000000); // return
      ld(32'h00000108, 32'h98280000, 32'hCAFE0001); // interrupt on carry true
      ld(32'h00000300, 32'h80047F80, 32'h00000400); // jump if data compare false
      ld(32'h00000400, 32'h98080000, 32'h00000044); // wrong path marker
      ld(32'h00000308, 32'h9F1A0000, 32'h00000000); // on-the-fly, phase message in
      ld(32'h00000310, 32'h80880000, 32'h00FFFFD8); // relative jump back 0x28
      ld(32'h000002F0, 32'h98880000, 32'h000002F0); // halt, relative bit ignored
      ld(32'h00000500, 32'hC0000008, 32'h00001000); // move 8 bytes
      mem_model.mem[32'h00000508] = 32'h00002000;
      ld(32'h0000050C, 32'h98080000, 32'h00000055); // halt after the move
      ld(32'h00000600, 32'hC0000008, 32'h00001001); // misaligned move
      mem_model.mem[32'h00000608] = 32'h00002002;
      ld(32'h00000700, 32'hC2000004, 32'h00001000); // reserved move bit 25
      mem_model.mem[32'h00000708] = 32'h00002000;
      ld(32'h00000800, 32'hA0080000, 32'h00000000); // reserved opcode
      repeat (5) @(posedge sys_clk);
      reset_n <= 1'b1;
      rd(8'h10, v);
      chk(v, 32'h00000000);
      chk({31'h0, irq_n}, 32'h00000001);
      rd(8'h18, v);
      chk(v, 32'h00000001);
      // latch message-in phase with one request assertion
      @(posedge sys_clk) {bus_phase_pins, bus_request_line_n} <= 4'hE;
      repeat (4) @(posedge sys_clk);
      bus_request_line_n <= 1'b1;
      // call, return, interrupt on carry
      alu_carry <= 1'b1;
      wr(8'h00, 32'h00000100);
      wstat(32'h00000001);
      chk({31'h0, irq_n}, 32'h00000000);
      rd(8'h08, v);
      chk(v, 32'h00000108);
      rd(8'h04, v);
      chk(v, 32'hCAFE0001);
      // not taken, on-the-fly phase hit, backward relative jump, slow memory
      mem_model.slow = 1'b1;
      @(posedge sys_clk) first_received_byte <= 8'h85;
      wr(8'h10, 32'h00000007);
      wr(8'h00, 32'h00000300);
      @(posedge sys_clk);
      #1 chk({31'h0, irq_n}, 32'h00000001);
      wstat(32'h00000001);
      rd(8'h04, v);
      chk(v, 32'h000002F0);
      rd(8'h10, v);
      chk(v, 32'h00000005);
      // memory move, both sides in I/O space
      wr(8'h0C, 32'h12345678);
      wr(8'h14, 32'h00000030);
      wr(8'h10, 32'h00000007);
      mem_model.n_bursts = 0;
      wr(8'h00, 32'h00000500);
      wstat(32'h00000001);
      chk(32'(mem_model.n_bursts), 32'h00000002);
      chk({30'h0, mem_model.first_burst[65:64]}, 32'h00000003);
      chk(mem_model.first_burst[63:32], 32'h00001000);
      chk(mem_model.first_burst[31:0], 32'h00002000);
      rd(8'h04, v);
      chk(v, 32'h00000055);
      rd(8'h0C, v);
      chk(v, 32'h12345678);
      // illegal instructions halt without the interrupt line
      foreach (bad_at[i]) begin
         wr(8'h10, 32'h00000007);
         wr(8'h00, bad_at[i]);
         wstat(32'h00000002);
         chk(v, 32'h00000002);
         chk({31'h0, irq_n}, 32'h00000001);
      end
      // target mode: wait bit holds the attention test until a new request
      ld(32'h00000900, 32'h808B0000, 32'h00000000); // relative +0, takes old request
      ld(32'h00000908, 32'h980B0000, 32'h00000066); // halt on attention, waits
      @(posedge sys_clk) {initiator_mode, bus_attention_line_n} <= 2'h0;
      wr(8'h10, 32'h00000007);
      wr(8'h00, 32'h00000900);
      repeat (30) @(posedge sys_clk);
      rd(8'h18, v);
      chk(v, 32'h00000004);
      @(posedge sys_clk) bus_request_line_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      bus_request_line_n <= 1'b1;
      wstat(32'h00000001);
      rd(8'h04, v);
      chk(v, 32'h00000066);
      chk({31'h0, irq_n}, 32'h00000000);
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
